// [rtl/iptc_map.svh]
// Register offsets, field positions, reset values and constant codes of the priority controller.
`ifndef IPTC_MAP_SVH
`define IPTC_MAP_SVH

// Word indexes; the byte address is four times the index.
`define IPTC_IDX_CTRL 6'h00
`define IPTC_IDX_STATUS 6'h01
`define IPTC_IDX_CAUSE 6'h02
`define IPTC_IDX_FLAG0 6'h04
`define IPTC_IDX_FLAG3 6'h07
`define IPTC_IDX_ENAB0 6'h08
`define IPTC_IDX_ENAB3 6'h0B
`define IPTC_IDX_PRIO0 6'h10
`define IPTC_IDX_PRIO13 6'h1D

// Control register fields.
`define IPTC_CTRL_NEST_BIT 0
`define IPTC_CTRL_LVL_LSB 4

// Reset cause bits.
`define IPTC_CAUSE_WDT 0
`define IPTC_CAUSE_UNINIT 1
`define IPTC_CAUSE_ILLEGAL 2
`define IPTC_CAUSE_LOCKOUT 3
`define IPTC_CAUSE_BROWNOUT 4

// Source map: reserved numbers and everything above 53 are set here.
`define IPTC_RSVD_MASK 64'hFFFF_E64F_C306_0000
`define IPTC_NUM_SRC 54
`define IPTC_VEC_OFS 8'h08
`define IPTC_ADDR_ERR_IDX 3'h4
`define IPTC_PRIO_RST 3'h0
`define IPTC_RESET_PC 24'h00_0000

`endif

// [rtl/iptc_pkg.sv]
// Types shared by the interrupt priority and trap controller.
package iptc_pkg;

   // Sequencer states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_OFFER = 3'b010,
      ST_RESET = 3'b100
   } iptc_state_t;

   // Request presented to the core.
   typedef struct packed {
      logic valid;
      logic is_trap;
      logic [3:0] level;
      logic [7:0] vector;
   } iptc_take_t;

endpackage

// [rtl/iptc_top.sv]
// Interrupt priority resolver, trap arbiter and reset source collector with a Wishbone slave.
//
// Summary of operation
// R1 - Each priority nibble holds a 3-bit field; nibble bit 3 reads zero.
// R2 - Priority 0 is lowest, 7 is highest.
// R3 - Interrupt number only breaks ties among equal-priority pending requests.
// R4 - Lower interrupt number wins a tie; 0 beats all, 53 loses.
// R5 - Vector number equals interrupt number plus eight.
// R6 - Listed reserved numbers have no source; others have one request line.
// R7 - Reset bypasses arbitration entirely.
// R8 - On reset the core restarts fetching at address zero.
// R9 - Watchdog expiry causes a device reset.
// R10 - Uninitialised pointer register use causes a device reset.
// R11 - Executed unused opcode resets; flushed illegal opcode does not.
// R12 - Simultaneous trap conditions cause a full reset, not a trap.
// R13 - Traps are non-maskable with fixed, unchangeable priority.
// R14 - Taking an invalid vector raises the address error trap.
// R15 - Software points unused trap vectors at a reset-only handler.
// R16 - Trapping instruction completes before trap processing starts.
// R17 - Traps use levels 8 to 15, so level MSB is set.
// R18 - Level 7 outside traps blocks interrupts but not traps.
// R19 - Traps may nest inside other traps.
// R20 - Flags set on events regardless of enable; software clears them.
// R21 - A source at priority 0 never interrupts.
// R22 - Interrupt taken only when priority strictly exceeds current level.
// R23 - Nesting disable blocks new interrupts in service and locks level bits.
// R24 - Reserved request lines are forced inactive.
`include "iptc_map.svh"
module iptc_top (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_nrst,
   // Wishbone classic slave.
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Peripheral and external request events.
   input wire logic [53:0] i_src_event,
   // Core handshake.
   input wire logic i_insn_done,
   input wire logic i_take_ack,
   input wire logic i_return,
   input wire logic [3:0] i_return_level,
   output iptc_pkg::iptc_take_t o_take,
   output logic [3:0] o_cpu_priority_level,
   // Trap conditions, bit i is the trap at level 8 plus i.
   input wire logic [7:0] i_trap_event,
   input wire logic i_vector_invalid,
   // Reset sources and the device reset request.
   input wire logic i_wdt_expire,
   input wire logic i_uninit_w_ptr,
   input wire logic i_illegal_exec,
   input wire logic i_flow_flush,
   input wire logic i_brownout_reset,
   output logic o_dev_reset,
   output logic [23:0] o_reset_pc
);

   // State.
   iptc_pkg::iptc_state_t state_ff;
   iptc_pkg::iptc_state_t nxt_state;
   iptc_pkg::iptc_take_t take_ff;
   iptc_pkg::iptc_take_t nxt_take;
   logic [63:0] flag_ff;
   logic [63:0] enab_ff;
   logic [2:0] prio_ff [0:53];
   logic [3:0] level_ff;
   logic [3:0] depth_ff;
   logic nest_dis_ff;
   logic [7:0] trap_pend_ff;
   logic [4:0] cause_ff;
   logic ack_ff;
   logic [31:0] rdat_ff;
   logic dev_reset_ff;

   // Bus decode.
   wire logic wb_hit = i_wb_cyc & i_wb_stb & ~ack_ff;
   wire logic wb_wr = wb_hit & i_wb_we;
   wire logic [5:0] widx = i_wb_adr[7:2];
   wire logic [15:0] wmask = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
   wire logic [15:0] wbits = i_wb_dat[15:0] & wmask;
   wire logic wr_ctrl = wb_wr & (widx == `IPTC_IDX_CTRL);
   wire logic wr_cause = wb_wr & (widx == `IPTC_IDX_CAUSE);
   wire logic wr_flag = wb_wr & (widx >= `IPTC_IDX_FLAG0) & (widx <= `IPTC_IDX_FLAG3);
   wire logic wr_enab = wb_wr & (widx >= `IPTC_IDX_ENAB0) & (widx <= `IPTC_IDX_ENAB3);
   wire logic wr_prio = wb_wr & (widx >= `IPTC_IDX_PRIO0) & (widx <= `IPTC_IDX_PRIO13);
   wire logic [1:0] wslot = widx[1:0];
   wire logic [3:0] prio_reg = 4'(widx - `IPTC_IDX_PRIO0);

   // Source validity: reserved numbers can never be pending.
   wire logic [63:0] src_valid = ~`IPTC_RSVD_MASK; // see R6
   wire logic [63:0] src_set = {10'h000, i_src_event} & src_valid; // see R24

   // Reset sources, gathered into one device reset request.
   wire logic [7:0] trap_new = i_trap_event
      | ({7'h00, i_vector_invalid} << `IPTC_ADDR_ERR_IDX); // see R14
   wire logic trap_multi = (trap_new & (trap_new - 8'h01)) != 8'h00;
   wire logic illegal_hit = i_illegal_exec & ~i_flow_flush; // see R11
   wire logic [4:0] cause_set = {i_brownout_reset, trap_multi, illegal_hit,
                                 i_uninit_w_ptr, i_wdt_expire}; // see R9 see R10 see R12
   wire logic soft_rst = |cause_set;

   // Software write masks for the clear-on-one flag words and the enable words.
   logic [63:0] flag_clr;
   logic [63:0] enab_wval;
   logic [63:0] enab_wmsk;
   always_comb begin
      flag_clr = 64'h0000_0000_0000_0000;
      enab_wval = 64'h0000_0000_0000_0000;
      enab_wmsk = 64'h0000_0000_0000_0000;
      if (wr_flag) begin
         flag_clr[16*wslot +: 16] = wbits;
      end
      if (wr_enab) begin
         enab_wval[16*wslot +: 16] = i_wb_dat[15:0];
         enab_wmsk[16*wslot +: 16] = wmask;
      end
   end

   // Interrupt arbitration over all sources.
   // A plain scan from 53 downward lets an equal priority at a lower number overwrite,
   // which gives the tie-break without a second comparator tree.
   wire logic [63:0] cand = flag_ff & enab_ff & src_valid;
   logic [5:0] best_num;
   logic [2:0] best_prio;
   logic best_found;
   always_comb begin
      best_num = 6'h00;
      best_prio = 3'h0;
      best_found = 1'b0;
      for (int n = 53; n >= 0; n--) begin
         if (cand[n] && prio_ff[n] != 3'h0 && prio_ff[n] >= best_prio) begin // see R2 see R21
            best_num = 6'(n); // see R3 see R4
            best_prio = prio_ff[n];
            best_found = 1'b1;
         end
      end
   end
   wire logic nest_block = nest_dis_ff & (depth_ff != 4'h0); // see R23
   wire logic irq_ok = best_found & ({1'b0, best_prio} > level_ff) & ~nest_block; // see R22 see R18

   // Trap arbitration: the highest pending level wins, nothing can mask it.
   logic [2:0] trap_idx;
   always_comb begin
      trap_idx = 3'h0;
      for (int n = 0; n < 8; n++) begin
         if (trap_pend_ff[n]) begin
            trap_idx = 3'(n); // see R13
         end
      end
   end
   wire logic trap_any = |trap_pend_ff;
   wire logic [3:0] trap_level = {1'b1, trap_idx}; // see R17
   wire logic trap_ok = trap_any & (trap_level > level_ff); // see R19

   // Candidate request for the core; traps outrank every interrupt.
   always_comb begin
      nxt_take = '0;
      if (trap_ok) begin
         nxt_take.valid = 1'b1;
         nxt_take.is_trap = 1'b1;
         nxt_take.level = trap_level;
         nxt_take.vector = {5'h00, trap_idx};
      end else if (irq_ok) begin
         nxt_take.valid = 1'b1;
         nxt_take.level = {1'b0, best_prio};
         nxt_take.vector = {2'h0, best_num} + `IPTC_VEC_OFS; // see R5
      end
   end

   // Sequencer. Offers start only at an instruction boundary so a trapping
   // instruction has completed; once offered the choice tracks the live winner.
   wire logic take_done = (state_ff == iptc_pkg::ST_OFFER) & take_ff.valid & i_take_ack;
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         iptc_pkg::ST_IDLE: begin
            if (i_insn_done && nxt_take.valid) begin // see R16
               nxt_state = iptc_pkg::ST_OFFER;
            end
         end
         iptc_pkg::ST_OFFER: begin
            if (take_done || !nxt_take.valid) begin
               nxt_state = iptc_pkg::ST_IDLE;
            end
         end
         iptc_pkg::ST_RESET: begin
            nxt_state = iptc_pkg::ST_IDLE;
         end
         default: begin
            nxt_state = iptc_pkg::ST_RESET;
         end
      endcase
      if (soft_rst) begin
         nxt_state = iptc_pkg::ST_RESET; // see R7
      end
   end

   // State register and the presented request. A reset never passes arbitration.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_ff <= iptc_pkg::ST_RESET;
         take_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         take_ff <= (nxt_state == iptc_pkg::ST_OFFER) && !take_done ? nxt_take : '0; // see R7
      end
   end

   // Request flags: an event wins over a clear in the same cycle.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         flag_ff <= 64'h0000_0000_0000_0000;
      end else if (soft_rst) begin
         flag_ff <= 64'h0000_0000_0000_0000;
      end else begin
         flag_ff <= (flag_ff & ~flag_clr) | src_set; // see R20
      end
   end

   // Enable bits, written per byte lane.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         enab_ff <= 64'h0000_0000_0000_0000;
      end else if (soft_rst) begin
         enab_ff <= 64'h0000_0000_0000_0000;
      end else begin
         enab_ff <= ((enab_ff & ~enab_wmsk) | (enab_wval & enab_wmsk)) & src_valid;
      end
   end

   // Priority fields, one small register per source.
   for (genvar n = 0; n < `IPTC_NUM_SRC; n++) begin : g_prio
      wire logic lane_on = (n % 4 < 2) ? i_wb_sel[0] : i_wb_sel[1];
      wire logic hit = wr_prio & (prio_reg == 4'(n / 4)) & lane_on;
      always_ff @(posedge i_clk or negedge i_nrst) begin
         if (!i_nrst) begin
            prio_ff[n] <= `IPTC_PRIO_RST;
         end else if (soft_rst) begin
            prio_ff[n] <= `IPTC_PRIO_RST;
         end else if (hit) begin
            prio_ff[n] <= i_wb_dat[4*(n%4) +: 3]; // see R1
         end
      end
   end

   // Control: nesting disable, and the low level bits unless locked.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         nest_dis_ff <= 1'b0;
      end else if (soft_rst) begin
         nest_dis_ff <= 1'b0;
      end else if (wr_ctrl && i_wb_sel[0]) begin
         nest_dis_ff <= i_wb_dat[`IPTC_CTRL_NEST_BIT];
      end
   end

   // Current level and service depth. Software may only touch bits 2:0, so it
   // can never clear the trap marker while a trap runs.
   wire logic lvl_wr = wr_ctrl & i_wb_sel[0] & ~nest_dis_ff; // see R23
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         level_ff <= 4'h0;
         depth_ff <= 4'h0;
      end else if (soft_rst) begin
         level_ff <= 4'h0;
         depth_ff <= 4'h0;
      end else if (take_done) begin
         level_ff <= take_ff.level; // see R17
         depth_ff <= (depth_ff == 4'hF) ? depth_ff : depth_ff + 4'h1;
      end else if (i_return) begin
         level_ff <= i_return_level;
         depth_ff <= (depth_ff == 4'h0) ? depth_ff : depth_ff - 4'h1;
      end else if (lvl_wr) begin
         level_ff <= {level_ff[3], i_wb_dat[`IPTC_CTRL_LVL_LSB +: 3]};
      end
   end

   // Pending traps: new conditions win over the clear from a taken trap.
   // Several at once are a lockout and become a reset instead.
   wire logic [7:0] trap_clr = take_done && take_ff.is_trap ?
      (8'h01 << take_ff.vector[2:0]) : 8'h00;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         trap_pend_ff <= 8'h00;
      end else if (soft_rst) begin
         trap_pend_ff <= 8'h00; // see R12
      end else begin
         trap_pend_ff <= (trap_pend_ff & ~trap_clr) | trap_new; // see R13
      end
   end

   // Reset cause: sticky, survives the device reset, write one to clear.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cause_ff <= 5'h00;
      end else begin
         cause_ff <= (cause_ff & ~(wr_cause ? wbits[4:0] : 5'h00)) | cause_set;
      end
   end

   // Device reset pulse; the core restarts its fetch at the reset address.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         dev_reset_ff <= 1'b0;
      end else begin
         dev_reset_ff <= soft_rst; // see R9 see R10 see R11
      end
   end

   // Read data selection.
   logic [31:0] rsel;
   always_comb begin
      rsel = 32'h0000_0000;
      if (widx == `IPTC_IDX_CTRL) begin
         rsel[`IPTC_CTRL_NEST_BIT] = nest_dis_ff;
         rsel[`IPTC_CTRL_LVL_LSB +: 4] = level_ff;
      end else if (widx == `IPTC_IDX_STATUS) begin
         rsel[15:0] = {take_ff.vector, take_ff.valid, take_ff.is_trap, 2'h0, depth_ff};
         rsel[19:16] = level_ff;
      end else if (widx == `IPTC_IDX_CAUSE) begin
         rsel[4:0] = cause_ff;
      end else if (widx >= `IPTC_IDX_FLAG0 && widx <= `IPTC_IDX_FLAG3) begin
         rsel[15:0] = flag_ff[16*wslot +: 16];
      end else if (widx >= `IPTC_IDX_ENAB0 && widx <= `IPTC_IDX_ENAB3) begin
         rsel[15:0] = enab_ff[16*wslot +: 16];
      end else if (widx >= `IPTC_IDX_PRIO0 && widx <= `IPTC_IDX_PRIO13) begin
         for (int j = 0; j < 4; j++) begin
            if (32'(prio_reg) * 4 + 32'(j) < `IPTC_NUM_SRC) begin
               rsel[4*j +: 3] = prio_ff[32'(prio_reg) * 4 + 32'(j)]; // see R1
            end
         end
      end
   end

   // Bus answer: one cycle after the strobe, unmapped words read zero.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ack_ff <= 1'b0;
         rdat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= wb_hit;
         rdat_ff <= wb_hit && !i_wb_we ? rsel : 32'h0000_0000;
      end
   end

   // Outputs straight from flip-flops, except the restart address, which is a constant.
   assign o_wb_ack = ack_ff;
   assign o_wb_dat = rdat_ff;
   assign o_take = take_ff;
   assign o_cpu_priority_level = level_ff;
   assign o_dev_reset = dev_reset_ff;
   assign o_reset_pc = `IPTC_RESET_PC; // see R8

endmodule

// [testbench/iptc_chk.sv]
// Port-level assertions for the interrupt priority and trap controller.
module iptc_chk (
   // Clock, reset and bus.
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   // Core handshake and reset sources.
   input wire logic i_insn_done,
   input wire logic i_take_ack,
   input wire iptc_pkg::iptc_take_t o_take,
   input wire logic [3:0] o_cpu_priority_level,
   input wire logic [7:0] i_trap_event,
   input wire logic i_vector_invalid,
   input wire logic i_wdt_expire,
   input wire logic i_uninit_w_ptr,
   input wire logic i_illegal_exec,
   input wire logic i_flow_flush,
   input wire logic i_brownout_reset,
   input wire logic o_dev_reset
);
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   // A fresh bus request, and an offer rising towards the core.
   sequence s_bus_req;
      i_wb_cyc && i_wb_stb && !o_wb_ack;
   endsequence
   sequence s_offer;
      !o_take.valid ##1 o_take.valid;
   endsequence
   // Other sources would reset anyway, so the flushed-opcode check needs them quiet.
   wire quiet = !(i_wdt_expire || i_uninit_w_ptr || i_brownout_reset);
   chk_ack_next: assert property (s_bus_req |=> o_wb_ack)
      else $error("bus request not answered next cycle");
   chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("bus ack longer than one cycle");
   chk_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0000_0000)
      else $error("read data not zero outside ack");
   chk_wdt_reset: assert property (i_wdt_expire |=> o_dev_reset)
      else $error("watchdog expiry gave no reset");
   chk_uninit_reset: assert property (i_uninit_w_ptr |=> o_dev_reset)
      else $error("uninitialised pointer gave no reset");
   chk_illegal_reset: assert property (i_illegal_exec && !i_flow_flush |=> o_dev_reset)
      else $error("illegal opcode gave no reset");
   chk_flush_spare: assert property (i_illegal_exec && i_flow_flush && quiet &&
      $countones({i_trap_event, i_vector_invalid}) < 2 |=> !o_dev_reset)
      else $error("flushed opcode caused a reset");
   chk_lockout_reset: assert property ($countones(i_trap_event) > 1 &&
      !o_cpu_priority_level[3] |=> o_dev_reset)
      else $error("simultaneous traps gave no reset");
   chk_reset_quiet: assert property (o_dev_reset |-> !o_take.valid &&
      o_cpu_priority_level == 4'h0)
      else $error("arbitration active during reset");
   chk_trap_level: assert property (o_take.valid && o_take.is_trap |->
      o_take.level[3] && o_take.vector == {5'h00, o_take.level[2:0]})
      else $error("trap level or vector wrong");
   chk_irq_vector: assert property (o_take.valid && !o_take.is_trap |->
      !o_take.level[3] && o_take.level != 4'h0 && o_take.vector inside {[8'h08:8'h34]})
      else $error("interrupt level or vector out of range");
   chk_offer_cause: assert property (s_offer |-> $past(i_insn_done))
      else $error("offer without instruction boundary");
   chk_irq_above: assert property (s_offer ##0 !o_take.is_trap |->
      o_take.level > o_cpu_priority_level)
      else $error("interrupt offered at or below level");
   chk_take_level: assert property (o_take.valid && i_take_ack |=>
      o_dev_reset || o_cpu_priority_level == $past(o_take.level))
      else $error("level not raised on take");
endmodule

bind iptc_top iptc_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_insn_done(i_insn_done),
   .i_take_ack(i_take_ack), .o_take(o_take), .o_cpu_priority_level(o_cpu_priority_level),
   .i_trap_event(i_trap_event), .i_vector_invalid(i_vector_invalid),
   .i_wdt_expire(i_wdt_expire), .i_uninit_w_ptr(i_uninit_w_ptr),
   .i_illegal_exec(i_illegal_exec), .i_flow_flush(i_flow_flush),
   .i_brownout_reset(i_brownout_reset), .o_dev_reset(o_dev_reset));

// [testbench/iptc_core_mdl.sv]
// Behavioural processor core that accepts offers and returns from handlers.
module iptc_core_mdl (
   // Clock, reset and test controls.
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_run,
   input wire logic i_slow,
   input wire logic i_unwind,
   // Controller side.
   input wire iptc_pkg::iptc_take_t i_take,
   input wire logic [3:0] i_level,
   input wire logic i_dev_reset,
   output logic o_insn_done,
   output logic o_take_ack,
   output logic o_return,
   output logic [3:0] o_return_level,
   output logic o_idle
);
   logic [3:0] stk_ff [0:15];
   logic [3:0] sp_ff;
   logic [1:0] cnt_ff;
   assign o_idle = sp_ff == 4'h0;
   // Slow mode spaces boundaries and delays acceptance, as a busy core would.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_insn_done <= 1'b0;
         o_take_ack <= 1'b0;
         o_return <= 1'b0;
         o_return_level <= 4'h0;
         cnt_ff <= 2'h0;
         sp_ff <= 4'h0;
      end else begin
         cnt_ff <= cnt_ff + 2'h1;
         o_insn_done <= i_run && (!i_slow || cnt_ff == 2'h0);
         o_return <= 1'b0;
         if (i_dev_reset) begin
            sp_ff <= 4'h0;
         end else if (o_take_ack) begin
            o_take_ack <= 1'b0;
         end else if (i_take.valid && (!i_slow || cnt_ff == 2'h3)) begin
            o_take_ack <= 1'b1;
            stk_ff[sp_ff] <= i_level;
            sp_ff <= sp_ff + 4'h1;
         end else if (i_unwind && sp_ff != 4'h0 && !o_return) begin
            o_return <= 1'b1;
            o_return_level <= stk_ff[sp_ff - 4'h1];
            sp_ff <= sp_ff - 4'h1;
         end
      end
   end
endmodule

// [testbench/iptc_top_tb.sv]
// Self-checking bench for the interrupt priority and trap controller.
module iptc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_nrst = 0, cyc = 0, stb = 0, we = 0;
   logic [7:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] wdat = 0, rdat;
   logic [53:0] ev = 0;
   logic [7:0] trap = 0;
   logic vinv = 0, wdt = 0, unin = 0, ill = 0, flush = 0, bor = 0;
   logic run = 0, slow = 0, unwind = 0;
   logic ack, insn, tack, ret, idle, devrst;
   logic [3:0] lvl, rlvl;
   logic [23:0] rpc;
   iptc_pkg::iptc_take_t take;
   logic [32:0] rq [$];
   logic [13:0] tq [$];
   logic [2:0] pr [0:55];
   int error_cnt = 0, compares = 0, rst_exp = 0, seed = 32'h4f74;
   iptc_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_src_event(ev), .i_insn_done(insn), .i_take_ack(tack), .i_return(ret),
      .i_return_level(rlvl), .o_take(take), .o_cpu_priority_level(lvl), .i_trap_event(trap),
      .i_vector_invalid(vinv), .i_wdt_expire(wdt), .i_uninit_w_ptr(unin), .i_illegal_exec(ill),
      .i_flow_flush(flush), .i_brownout_reset(bor), .o_dev_reset(devrst), .o_reset_pc(rpc));
   iptc_core_mdl core (.i_clk(i_clk), .i_nrst(i_nrst), .i_run(run), .i_slow(slow),
      .i_unwind(unwind), .i_take(take), .i_level(lvl), .i_dev_reset(devrst),
      .o_insn_done(insn), .o_take_ack(tack), .o_return(ret), .o_return_level(rlvl),
      .o_idle(idle));
   // The 40 ns clock.
   initial forever #20 i_clk = ~i_clk;
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up();
      if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One classic cycle; a read notes its expected word, which the monitor compares.
   task automatic wb(input logic w, input logic [5:0] ix, input logic [15:0] d);
      @(posedge i_clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= {ix, 2'b00};
      sel <= 4'hF;
      wdat <= {16'h0000, d};
      rq.push_back({!w, 16'h0000, d});
      do begin
         @(posedge i_clk);
      end while (!ack);
      cyc <= 0;
      stb <= 0;
   endtask
   // Events in one cycle only, so that all of them become pending together.
   task automatic fire(input logic [53:0] e, input logic [7:0] t, input logic v);
      @(posedge i_clk);
      ev <= e;
      trap <= t;
      vinv <= v;
      @(posedge i_clk);
      ev <= 0;
      trap <= 0;
      vinv <= 0;
   endtask
   // Waits for the noted takes to be used up, or unwinds the core to its base level.
   task automatic wt(input bit dr);
      unwind <= !dr;
      do begin
         @(posedge i_clk);
      end while (dr ? tq.size() > 0 : !idle);
      unwind <= 0;
   endtask
   task automatic settle();
      wt(1);
      for (int i = 4; i < 8; i++) wb(1, 6'(i), 16'hFFFF);
      wt(0);
      wt(1);
      wt(0);
   endtask
   task automatic setp(input int s, input logic [2:0] p);
      int b;
      pr[s] = p;
      b = s - s % 4;
      wb(1, 6'(16 + s / 4), {1'b0, pr[b+3], 1'b0, pr[b+2], 1'b0, pr[b+1], 1'b0, pr[b]});
   endtask
   function automatic logic [13:0] irq_t(int s, int p);
      return {3'b100, p[2:0], 8'(s + 8)};
   endfunction
   function automatic logic [13:0] trap_t(int i);
      return {3'b111, i[2:0], 5'h00, i[2:0]};
   endfunction
   function automatic bit rsv(int s);
      return s inside {17, 18, 24, 25, [30:35], 38, 41, 42, [45:53]};
   endfunction
   // Every bus answer and every accepted offer retires the oldest note of its kind.
   always @(posedge i_clk) begin
      if (ack && rq.size() > 0) begin
         if (rq[0][32]) cmp("read data", {16'h0000, rq[0][15:0]}, rdat);
         void'(rq.pop_front());
      end
      if (take.valid && tack) begin
         cmp("take", tq.size() > 0 ? {18'h0, tq[0]} : 32'hFFFF_FFFF, {18'h0, take});
         if (tq.size() > 0) void'(tq.pop_front());
      end
      if (devrst) begin
         cmp("device reset", 32'h1, {31'h0, rst_exp > 0});
         if (rst_exp > 0) rst_exp--;
      end
   end
   // A hung wait ends the run as a failure.
   initial begin
      repeat (30000) @(posedge i_clk);
      error_cnt++;
      wrap_up();
   end
   initial begin
      for (int i = 0; i < 56; i++) pr[i] = 0;
      repeat (16) @(posedge i_clk);
      i_nrst <= 1;
      wb(0, 6'h00, 0);
      wb(0, 6'h10, 0);
      wb(1, 6'h3F, 16'hFFFF);
      wb(0, 6'h03, 0);
      cmp("restart address", 0, {8'h0, rpc});
      wb(1, 6'h10, 16'hFFFF);
      wb(0, 6'h10, 16'h7777);
      wb(1, 6'h10, 0);
      // Flags set with enables off; then priority 0 keeps enabled sources silent.
      run <= 1;
      fire({54{1'b1}}, 0, 0);
      wb(0, 6'h04, 16'hFFFF);
      wb(0, 6'h05, 16'h3CF9);
      wb(0, 6'h06, 16'h19B0);
      wb(0, 6'h07, 16'h0000);
      for (int i = 8; i < 12; i++) wb(1, 6'(i), 16'hFFFF);
      repeat (10) @(posedge i_clk);
      settle();
      // Pairs raised together: corner cases first, then random sources and priorities.
      for (int k = 0; k < 10; k++) begin
         int a, b;
         logic [2:0] pa, pb;
         do a = $unsigned($random(seed)) % 54; while (rsv(a));
         do b = $unsigned($random(seed)) % 54; while (rsv(b) || b == a);
         pa = 3'(6 + $unsigned($random(seed)) % 2);
         pb = 3'(6 + $unsigned($random(seed)) % 2);
         if (k == 0) {a, b, pa, pb} = {32'd5, 32'd3, 3'd4, 3'd4};
         if (k == 1) {a, b, pa, pb} = {32'd0, 32'd44, 3'd1, 3'd7};
         if (k == 2) {a, b, pa, pb} = {32'd44, 32'd43, 3'd5, 3'd5};
         setp(a, pa);
         setp(b, pb);
         if (pa > pb || (pa == pb && a < b)) tq.push_back(irq_t(a, pa));
         else tq.push_back(irq_t(b, pb));
         slow <= k[0];
         fire((54'h1 << a) | (54'h1 << b), 0, 0);
         settle();
         setp(a, 0);
         setp(b, 0);
      end
      // Level 7 shuts interrupts out while traps enter and nest.
      setp(44, 7);
      wb(1, 6'h00, 16'h0070);
      fire(54'h1 << 44, 0, 0);
      repeat (10) @(posedge i_clk);
      tq.push_back(trap_t(0));
      fire(0, 8'h01, 0);
      wt(1);
      tq.push_back(trap_t(3));
      fire(0, 8'h08, 0);
      wt(1);
      tq.push_back(trap_t(4));
      fire(0, 0, 1);
      settle();
      wb(1, 6'h00, 16'h0001);
      // With the core stalled, the higher trap wins; the lower one follows on return.
      run <= 0;
      fire(0, 8'h04, 0);
      fire(0, 8'h40, 0);
      tq.push_back(trap_t(6));
      run <= 1;
      wt(1);
      tq.push_back(trap_t(2));
      wt(0);
      settle();
      // Nesting disable locks the level and holds off a higher interrupt in service.
      wb(1, 6'h00, 16'h0071);
      wb(0, 6'h00, 16'h0001);
      setp(3, 3);
      tq.push_back(irq_t(3, 3));
      fire(54'h1 << 3, 0, 0);
      wt(1);
      fire(54'h1 << 44, 0, 0);
      repeat (10) @(posedge i_clk);
      settle();
      wb(1, 6'h00, 0);
      // Each reset source alone, lockout as two traps at once, then a flushed opcode.
      for (int i = 0; i < 5; i++) begin
         @(posedge i_clk);
         {bor, trap[1], ill, unin, wdt} <= 5'b00001 << i;
         trap[0] <= (i == 3);
         rst_exp++;
         @(posedge i_clk);
         {bor, trap, ill, unin, wdt} <= 0;
         repeat (3) @(posedge i_clk);
      end
      @(posedge i_clk);
      ill <= 1;
      flush <= 1;
      @(posedge i_clk);
      ill <= 0;
      flush <= 0;
      repeat (4) @(posedge i_clk);
      wb(0, 6'h02, 16'h001F);
      wb(0, 6'h1A, 0);
      cmp("unmet notes", 0, rst_exp + tq.size());
      wrap_up();
   end
endmodule
